// ### core/srctl_pkg.sv
// Purpose: shared constants for the sampler run control block
// Assumes: 100 MHz clock, classic Wishbone register access
// Notes:   register offsets are byte addresses of aligned words
package srctl_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ           = 100_000_000;
	localparam int unsigned TICK_PERIOD_S    = 1;
	localparam int unsigned CYCLES_PER_TICK  = CLK_HZ * TICK_PERIOD_S;
	localparam int unsigned RUN_FAULT_TIME_S = 3;
	localparam int unsigned RUN_FAULT_TICKS  = RUN_FAULT_TIME_S
	                                           / TICK_PERIOD_S;
	localparam int unsigned TICK_CNT_W       = 32;
	localparam int unsigned SEC_CNT_W        = 4;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int unsigned ADR_W       = 4;
	localparam logic [3:0]  CTRL_ADR    = 4'h0;
	localparam logic [3:0]  STATUS_ADR  = 4'h4;

	// control register, write-one pulse bits, read as zero
	localparam int unsigned CTRL_AUTO_BIT   = 0;
	localparam int unsigned CTRL_MANUAL_BIT = 1;
	localparam int unsigned CTRL_START_BIT  = 2;
	localparam int unsigned CTRL_STOP_BIT   = 3;

	// status register, read only
	localparam int unsigned STAT_MANUAL_BIT = 0;
	localparam int unsigned STAT_RUN_BIT    = 1;
	localparam int unsigned STAT_FAIL_BIT   = 2;
	localparam int unsigned STAT_FAULT_BIT  = 3;
	localparam int unsigned STAT_REMOTE_BIT = 4;
	localparam int unsigned STAT_ON_BIT     = 5;
	localparam int unsigned STAT_INITR_BIT  = 6;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic MANUAL_RST = 1'b1;
	localparam logic RUN_RST    = 1'b0;

	typedef enum logic {
		SRCTL_AUTO,
		SRCTL_MANUAL
	} srctl_mode_t;

endpackage : srctl_pkg

// ### core/srctl_sec_timer.sv
// Purpose: seconds tick divider with restart, counts whole seconds held
// Assumes: single clock, synchronous active-low reset
// Notes:   restart_i zeroes both the divider and the seconds count
`timescale 1ns/1ps
`default_nettype none
module srctl_sec_timer #(
	parameter int unsigned CYCLES_PER_TICK = srctl_pkg::CYCLES_PER_TICK
) (
	// clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          resetn_i,
	// control
	input  wire logic                          restart_i,
	// count of whole seconds since restart, saturating
	output logic [srctl_pkg::SEC_CNT_W-1:0]    seconds_o
);

	localparam logic [srctl_pkg::TICK_CNT_W-1:0] TICK_LAST =
		srctl_pkg::TICK_CNT_W'(CYCLES_PER_TICK - 1);
	localparam logic [srctl_pkg::SEC_CNT_W-1:0] SEC_MAX = '1;

	logic [srctl_pkg::TICK_CNT_W-1:0] div_cnt;
	logic                             tick;

	// ----------------------------------------------------------------
	// seconds tick divider
	// ----------------------------------------------------------------
	assign tick = (div_cnt == TICK_LAST);

	// divider restarts with the held condition so a second is exact
	always_ff @(posedge clk_i) begin
		if (!resetn_i || restart_i || tick) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	// seconds count, saturates so a long hold never wraps
	always_ff @(posedge clk_i) begin
		if (!resetn_i || restart_i) begin
			seconds_o <= '0;
		end else if (tick && seconds_o != SEC_MAX) begin
			seconds_o <= seconds_o + 1'b1;
		end
	end

endmodule : srctl_sec_timer
`default_nettype wire

// ### core/srctl_top.sv
// Purpose: auto/manual run control with fail and run-fault alarms
// Assumes: field inputs synchronous to clk_i, classic Wishbone slave
// Notes:   the interlocked status output never asserts for alarms;
//          alarms clear by themselves, there is no alarm reset command;
//          after manual to auto the run command waits for initiate to
//          agree with it before tracking, so the switch is bumpless
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - a write-one pulse on auto select puts the block in auto mode.
// - a write-one pulse on manual select puts it in manual mode, shown.
// - remote, run command and not-on held 3 s raise run fault, auto clear.
// - fail or run fault forces run off in both modes, not interlocked.
// - in auto with no alarm the run command follows initiate run.
// - switching modes keeps the present run command with no step.
module srctl_top #(
	parameter int unsigned CYCLES_PER_TICK = srctl_pkg::CYCLES_PER_TICK
) (
	// clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     resetn_i,
	// wishbone slave
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [srctl_pkg::ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic [31:0]                   wb_dat_o,
	output logic                          wb_ack_o,
	// field sampler
	input  wire logic                     remote_controlled_i,
	input  wire logic                     equipment_fail_in_i,
	input  wire logic                     equipment_on_i,
	input  wire logic                     initiate_run_in_i,
	output logic                          run_command_out_o,
	// status
	output logic                          manual_mode_out_o,
	output logic                          fail_alarm_o,
	output logic                          run_fault_alarm_o,
	output logic                          interlocked_o
);

	// commands in the control word, bit 0 up to the stop bit
	localparam int unsigned CMD_BITS = srctl_pkg::CTRL_STOP_BIT + 1;
	// whole seconds the run fault cause must hold
	localparam logic [srctl_pkg::SEC_CNT_W-1:0] FAULT_SECS =
		srctl_pkg::SEC_CNT_W'(srctl_pkg::RUN_FAULT_TICKS);

	// operating mode, manual after reset
	srctl_pkg::srctl_mode_t mode;

	// bus decode and read data
	logic        wb_req;
	logic        ctrl_wr;
	logic [31:0] next_rdata;

	// operator commands; start/stop index 0 starts, 1 stops
	logic [CMD_BITS-1:0] ctrl_cmd;
	logic        auto_select_pulse;
	logic        manual_select_pulse;
	logic [1:0]  manual_start_stop_pulse;
	logic        auto_entry;

	// alarm path
	logic        fault_cond;
	logic        fault_restart;
	logic        fault_timed;
	logic [srctl_pkg::SEC_CNT_W-1:0] fault_secs;
	logic        interlock;

	// run path
	logic        synced;

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------
	assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign ctrl_wr = wb_req && wb_we_i && wb_sel_i[0]
	                 && (wb_adr_i == srctl_pkg::CTRL_ADR);

	// operator commands are one-cycle pulses, nothing to clear;
	// each control word bit pulses only while a write is taken
	for (genvar g = 0; g < CMD_BITS; g++) begin : g_cmd
		assign ctrl_cmd[g] = ctrl_wr && wb_dat_i[g];
	end

	// named commands picked out of the pulse vector
	assign auto_select_pulse   =
		ctrl_cmd[srctl_pkg::CTRL_AUTO_BIT];
	assign manual_select_pulse =
		ctrl_cmd[srctl_pkg::CTRL_MANUAL_BIT];
	assign manual_start_stop_pulse[0] =
		ctrl_cmd[srctl_pkg::CTRL_START_BIT];
	assign manual_start_stop_pulse[1] =
		ctrl_cmd[srctl_pkg::CTRL_STOP_BIT];

	// read mux, control and unmapped addresses read zero
	always_comb begin
		next_rdata = '0;
		if (wb_adr_i == srctl_pkg::STATUS_ADR) begin
			next_rdata[srctl_pkg::STAT_MANUAL_BIT] = manual_mode_out_o;
			next_rdata[srctl_pkg::STAT_RUN_BIT]    = run_command_out_o;
			next_rdata[srctl_pkg::STAT_FAIL_BIT]   = fail_alarm_o;
			next_rdata[srctl_pkg::STAT_FAULT_BIT]  = run_fault_alarm_o;
			next_rdata[srctl_pkg::STAT_REMOTE_BIT] = remote_controlled_i;
			next_rdata[srctl_pkg::STAT_ON_BIT]     = equipment_on_i;
			next_rdata[srctl_pkg::STAT_INITR_BIT]  = initiate_run_in_i;
		end
	end

	// ack one cycle after the request, every address answers;
	// the ack itself blocks a second take of the same request
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= next_rdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// control mode
	// ----------------------------------------------------------------
	// manual wins if both selects arrive together, the safer choice
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			mode <= srctl_pkg::SRCTL_MANUAL;
		end else if (manual_select_pulse) begin
			mode <= srctl_pkg::SRCTL_MANUAL;
		end else if (auto_select_pulse) begin
			mode <= srctl_pkg::SRCTL_AUTO;
		end
	end

	assign manual_mode_out_o = (mode == srctl_pkg::SRCTL_MANUAL);

	// ----------------------------------------------------------------
	// alarms
	// ----------------------------------------------------------------
	// run fault cause: under remote control, commanded, yet not on
	assign fault_cond = remote_controlled_i && run_command_out_o
	                    && !equipment_on_i;

	// the timer restarts whenever the cause lapses, so only a
	// continuous hold counts toward the alarm
	assign fault_restart = !fault_cond;
	assign fault_timed   = (fault_secs >= FAULT_SECS);

	srctl_sec_timer #(
		.CYCLES_PER_TICK (CYCLES_PER_TICK)
	) u_fault_timer (
		.clk_i     (clk_i),
		.resetn_i  (resetn_i),
		.restart_i (fault_restart),
		.seconds_o (fault_secs)
	);

	// both alarms clear by themselves once their cause is gone
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			fail_alarm_o      <= 1'b0;
			run_fault_alarm_o <= 1'b0;
		end else begin
			fail_alarm_o      <= equipment_fail_in_i;
			run_fault_alarm_o <= fault_cond && fault_timed;
		end
	end

	// ----------------------------------------------------------------
	// interlock
	// ----------------------------------------------------------------
	// either alarm stops the run; it is not an interlock for status
	assign interlock     = fail_alarm_o || run_fault_alarm_o;
	assign interlocked_o = 1'b0;

	// ----------------------------------------------------------------
	// run command
	// ----------------------------------------------------------------
	// a manual to auto switch, manual select wins over auto select
	assign auto_entry = auto_select_pulse && !manual_select_pulse
	                    && (mode == srctl_pkg::SRCTL_MANUAL);

	// after a switch to auto, hold until initiate agrees with the run
	// command, so the mode change itself never steps the output
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			synced <= 1'b1;
		end else if (interlock) begin
			synced <= 1'b1;
		end else if (auto_entry) begin
			synced <= 1'b0;
		end else if (initiate_run_in_i == run_command_out_o) begin
			synced <= 1'b1;
		end
	end

	// run command, alarms first, then the manual or auto source
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			run_command_out_o <= srctl_pkg::RUN_RST;
		end else if (interlock) begin
			run_command_out_o <= 1'b0;
		end else if (mode == srctl_pkg::SRCTL_MANUAL) begin
			if (manual_start_stop_pulse[1]) begin
				run_command_out_o <= 1'b0;
			end else if (manual_start_stop_pulse[0]) begin
				run_command_out_o <= 1'b1;
			end
		end else if (synced) begin
			run_command_out_o <= initiate_run_in_i;
		end
	end

endmodule : srctl_top
`default_nettype wire

// ### bench/srctl_checker.sv
// Purpose: port assertions for srctl_top
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every srctl_top instance
`timescale 1ns/1ps
`default_nettype none
module srctl_checker #(
	parameter int unsigned CYCLES_PER_TICK = 10
) (
	// clock, reset and bus
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// field and status
	input wire logic remote_controlled_i,
	input wire logic equipment_fail_in_i,
	input wire logic equipment_on_i,
	input wire logic initiate_run_in_i,
	input wire logic run_command_out_o,
	input wire logic manual_mode_out_o,
	input wire logic fail_alarm_o,
	input wire logic run_fault_alarm_o,
	input wire logic interlocked_o
);
	localparam int FT = 3 * CYCLES_PER_TICK;
	logic [7:0] held;
	wire logic  cond = remote_controlled_i & run_command_out_o
	                   & ~equipment_on_i;
	wire logic  alarm = fail_alarm_o | run_fault_alarm_o;
	wire logic  req = wb_cyc_i & wb_stb_i;
	// cycles the run-fault condition has held
	always_ff @(posedge clk_i) begin
		if (!resetn_i)
			held <= 8'h00;
		else
			held <= cond ? held + 8'h01 : 8'h00;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	ack_timing_a: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("no ack one cycle after request");
	fail_follow_a: assert property ($past(resetn_i) |->
		fail_alarm_o == $past(equipment_fail_in_i))
		else $error("fail alarm does not follow fail input");
	alarm_stop_a: assert property (alarm |=> !run_command_out_o)
		else $error("run left on during alarm");
	no_intlock_a: assert property (!interlocked_o)
		else $error("interlocked set");
	fault_time_a: assert property (held == FT + 1 |-> run_fault_alarm_o)
		else $error("run fault late");
	fault_rise_a: assert property ($rose(run_fault_alarm_o) |->
		held == FT + 1)
		else $error("run fault early");
	fault_clear_a: assert property (!cond |=> !run_fault_alarm_o)
		else $error("run fault not cleared");
	auto_follow_a: assert property (!manual_mode_out_o && !alarm
		&& !req && run_command_out_o == initiate_run_in_i
		|=> run_command_out_o == $past(initiate_run_in_i))
		else $error("auto run does not track initiate");
	manual_hold_a: assert property (manual_mode_out_o && !req
		&& !alarm |=> $stable(run_command_out_o))
		else $error("manual run moved without command");
	mode_bump_a: assert property ($changed(manual_mode_out_o)
		&& !$past(alarm) |-> $stable(run_command_out_o))
		else $error("mode switch stepped run");
	cover property (run_fault_alarm_o);
	cover property (fail_alarm_o && !run_command_out_o);
	cover property ($fell(manual_mode_out_o));
endmodule : srctl_checker
bind srctl_top srctl_checker #(.CYCLES_PER_TICK(CYCLES_PER_TICK)) i_chk (
	.clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.remote_controlled_i, .equipment_fail_in_i, .equipment_on_i,
	.initiate_run_in_i, .run_command_out_o, .manual_mode_out_o,
	.fail_alarm_o, .run_fault_alarm_o, .interlocked_o);
`default_nettype wire

// ### bench/srctl_sampler_model.sv
// Purpose: field sampler stand-in
// Assumes: shares the block clock
// Notes:   stuck_i makes it ignore run commands, at_station_i local mode
`timescale 1ns/1ps
`default_nettype none
module srctl_sampler_model (
	// clock and fault injection
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic stuck_i,
	input wire logic at_station_i,
	// status back to the block
	output logic     remote_o,
	output logic     on_o
);
	// remote unless switched to its local station
	assign remote_o = ~at_station_i;
	// on follows run one cycle late unless stuck
	always_ff @(posedge clk_i) begin
		on_o <= run_i & ~stuck_i;
	end
endmodule : srctl_sampler_model
`default_nettype wire

// ### bench/test_sampler_run_control.sv
// Purpose: bus and field test of srctl_top
// Assumes: CYCLES_PER_TICK of 10, so 3 s is 30 cycles
// Notes:   outs packs manual, run, fail, fault, interlocked
`timescale 1ns/1ps
`default_nettype none
module test_sampler_run_control;
	logic        clk_i = 1'b0, resetn_i = 1'b0, stuck = 1'b0, init = 1'b0;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, fail = 1'b0;
	logic        ack, run, man, falm, flt, ilk, remote, on;
	logic        at_station = 1'b0;
	logic [3:0]  adr = 4'h0, sel = 4'h0;
	logic [31:0] dat = 32'h0, q, rdat;
	int          errors = 0, compares = 0, n;
	wire logic [31:0] outs = {27'h0, man, run, falm, flt, ilk};
	// block under test and far-side sampler
	srctl_top #(.CYCLES_PER_TICK(10)) i_dut (.clk_i(clk_i),
		.resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q),
		.wb_ack_o(ack), .remote_controlled_i(remote),
		.equipment_fail_in_i(fail), .equipment_on_i(on),
		.initiate_run_in_i(init), .run_command_out_o(run),
		.manual_mode_out_o(man), .fail_alarm_o(falm),
		.run_fault_alarm_o(flt), .interlocked_o(ilk));
	srctl_sampler_model i_far (.clk_i(clk_i), .run_i(run),
		.stuck_i(stuck), .at_station_i(at_station), .remote_o(remote),
		.on_o(on));
	// 100 MHz clock
	always #5 clk_i = ~clk_i;
	// verdict
	task automatic summarize();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask : check
	// one Wishbone cycle; a read is compared with e
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d, input logic [31:0] e);
		@(posedge clk_i);
		{cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hf, d};
		for (n = 0; n < 50 && ack !== 1'b1; n++) @(posedge clk_i);
		rdat = q;
		{cyc, stb} <= 2'b00;
		if (n == 50) begin
			errors++;
			summarize();
		end
		if (!w) check(rdat, e);
	endtask : bus
	// wait edges, then look at settled outputs
	task automatic settle(input int k);
		repeat (k) @(posedge clk_i);
		@(negedge clk_i);
	endtask : settle
	// test sequence
	initial begin
		repeat (20) @(posedge clk_i);
		resetn_i <= 1'b1;
		settle(0);
		check(outs, 32'h10);
		bus(1'b0, 4'h4, 32'h0, 32'h11);
		bus(1'b0, 4'h8, 32'h0, 32'h0);
		bus(1'b0, 4'h0, 32'h0, 32'h0);
		$display("test reset done");
		bus(1'b1, 4'h0, 32'h4, 32'h0);
		bus(1'b0, 4'h4, 32'h0, 32'h33);
		bus(1'b1, 4'h0, 32'hc, 32'h0);
		settle(0);
		check(outs, 32'h10);
		bus(1'b1, 4'h0, 32'h4, 32'h0);
		bus(1'b1, 4'h0, 32'h1, 32'h0);
		settle(0);
		check(outs, 32'h08);
		@(posedge clk_i) init <= 1'b1;
		@(posedge clk_i) init <= 1'b0;
		settle(1);
		check(outs, 32'h00);
		@(posedge clk_i) init <= 1'b1;
		settle(1);
		check(outs, 32'h08);
		bus(1'b1, 4'h0, 32'h2, 32'h0);
		settle(0);
		check(outs, 32'h18);
		bus(1'b1, 4'h0, 32'h1, 32'h0);
		bus(1'b1, 4'h0, 32'h3, 32'h0);
		bus(1'b0, 4'h4, 32'h0, 32'h73);
		bus(1'b1, 4'h0, 32'h1, 32'h0);
		$display("test modes done");
		@(posedge clk_i) stuck <= 1'b1;
		for (n = 0; n < 100 && flt !== 1'b1; n++) @(negedge clk_i);
		check(n, 32'h21);
		if (n == 100) summarize();
		settle(0);
		check(outs, 32'h02);
		settle(0);
		check(outs, 32'h00);
		@(posedge clk_i) stuck <= 1'b0;
		settle(2);
		check(outs, 32'h08);
		@(posedge clk_i) fail <= 1'b1;
		settle(1);
		check(outs, 32'h0c);
		settle(2);
		bus(1'b0, 4'h4, 32'h0, 32'h54);
		@(posedge clk_i) fail <= 1'b0;
		settle(2);
		check(outs, 32'h08);
		@(posedge clk_i) {at_station, stuck} <= 2'b11;
		settle(40);
		check(outs, 32'h08);
		bus(1'b0, 4'h4, 32'h0, 32'h42);
		@(posedge clk_i) {at_station, stuck} <= 2'b00;
		bus(1'b1, 4'h0, 32'h8, 32'h0);
		settle(0);
		check(outs, 32'h08);
		$display("test alarms done");
		summarize();
	end
endmodule : test_sampler_run_control
`default_nettype wire
